// ---- ssm_status_monitor.sv ----
// Purpose: safety state, error severity and cause reporting
// Assumes: all inputs synchronous to ref_clk
// Notes: faults latch the first cause, a severe one replaces an io cause; severe ones never clear
`timescale 1ns/100ps
module ssm_status_monitor #(
  parameter int PULSE_PERIOD = ssm_pkg::PULSE_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register port
  input wire ssm_pkg::ssm_bus_s bus_req,
  output logic [7:0] rd_data,
  // torque off enables and monitors
  input wire logic torque_off_en_a,
  input wire logic torque_off_en_b,
  input wire logic stage_en_mon_a,
  input wire logic stage_en_mon_b,
  output logic power_stage_en,
  output logic brake_release,
  // internal supply
  input wire logic supply_ok,
  output logic torque_off_ctrl_bit,
  // safe output with test pulses
  input wire logic safe_out_cmd,
  input wire logic safe_out_level,
  output logic safe_out_drive,
  // acknowledge input
  input wire logic ack_in,
  output logic ack_request,
  // firmware status and diagnostics
  input wire ssm_pkg::ssm_life_s life,
  input wire ssm_pkg::ssm_diag_s diag
);
  import ssm_pkg::*;

  // lowest set cause in a fault vector wins
  function automatic logic [7:0] first_cause(
    input logic [CAUSE_MAX:1] vec
  );
    logic [7:0] code;
    code = CAUSE_NONE;
    for (int i = CAUSE_MAX; i >= 1; i--) begin
      if (vec[i]) begin
        code = 8'(i);
      end
    end
    return code;
  endfunction : first_cause

  // causes that need a power cycle
  function automatic logic is_severe(input logic [7:0] code);
    return (code == CAUSE_TQ_OUT) || (code == CAUSE_SUPPLY) ||
           (code == CAUSE_RAM) || (code == CAUSE_FW_CRC) ||
           (code == CAUSE_CPU) || (code == CAUSE_STACK);
  endfunction : is_severe

  // state machine
  ssm_state_e state_reg;
  ssm_state_e state_next;
  // reported bytes
  logic [7:0] sys_state_reg;
  logic [7:0] err_sev_reg;
  logic [7:0] err_cause_reg;
  // feedback and supply flags
  logic fb_a_reg;
  logic fb_b_reg;
  logic supply_good_reg;
  // output flops
  logic [7:0] rd_data_reg;
  logic power_stage_en_reg;
  logic brake_release_reg;
  logic safe_out_drive_reg;
  logic ack_request_reg;
  // brake test control pulses from software
  logic brk_start;
  logic brk_end;
  // test pulse counter and safe output check
  logic [31:0] pulse_cnt_reg;
  logic out_fault_reg;
  // acknowledge edge detection
  logic ack_prev_reg;
  logic ack_edge;
  logic ack_taken;
  logic ack_stray;
  // fault gathering
  logic [CAUSE_MAX:1] fault_vec;
  logic [7:0] new_cause;
  logic operating;

  // software commands decode
  assign brk_start = bus_req.wr && (bus_req.addr == OFS_CTRL) &&
                     bus_req.wdata[CTRL_BRK_START];
  assign brk_end = bus_req.wr && (bus_req.addr == OFS_CTRL) &&
                   bus_req.wdata[CTRL_BRK_END];

  // operating states where the supply must hold
  assign operating = (state_reg == ST_OPER) ||
                     (state_reg == ST_OPER_NOENC) ||
                     (state_reg == ST_BRAKE_TEST);

  // acknowledge toggles, accepted only when requested
  assign ack_edge = ack_in ^ ack_prev_reg;
  assign ack_taken = ack_edge && ack_request_reg;
  assign ack_stray = ack_edge && !ack_request_reg;

  // fault vector indexed by cause code
  always_comb begin
    fault_vec = '0;
    fault_vec[1] = diag.safe_input;
    fault_vec[2] = out_fault_reg;
    fault_vec[3] = diag.torque_off_out;
    fault_vec[4] = ack_stray;
    fault_vec[5] = diag.encoder_comm;
    fault_vec[6] = diag.encoder_check;
    fault_vec[7] = operating && !supply_good_reg;
    fault_vec[8] = diag.fieldbus;
    fault_vec[9] = diag.ram;
    fault_vec[10] = diag.fw_crc;
    fault_vec[11] = diag.cpu;
    fault_vec[12] = diag.stack;
    fault_vec[13] = diag.param_invalid;
  end
  assign new_cause = first_cause(fault_vec);

  // next system state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      // waiting for the module to start
      ST_POWER_UP: begin
        if (life.module_start) begin
          state_next = ST_START_UP;
        end
      end
      // start up, including fieldbus link set up
      ST_START_UP: begin
        if (life.flash_load_req) begin
          state_next = ST_FLASH;
        end else if (life.config_bad) begin
          state_next = ST_CONFIG;
        end else if (life.link_up) begin
          state_next = ST_OPER;
        end
      end
      // new configuration required
      ST_CONFIG: begin
        if (life.flash_load_req) begin
          state_next = ST_FLASH;
        end else if (life.config_ok) begin
          state_next = ST_START_UP;
        end
      end
      // normal operation with encoder
      ST_OPER: begin
        if (brk_start) begin
          state_next = ST_BRAKE_TEST;
        end else if (!life.encoder_active) begin
          state_next = ST_OPER_NOENC;
        end
      end
      // normal operation without safety encoder
      ST_OPER_NOENC: begin
        if (brk_start) begin
          state_next = ST_BRAKE_TEST;
        end else if (life.encoder_active) begin
          state_next = ST_OPER;
        end
      end
      // brake test started by the drive processor
      ST_BRAKE_TEST: begin
        if (brk_end) begin
          state_next = ST_OPER;
        end
      end
      // parameter set loading from flash card
      ST_FLASH: begin
        if (life.flash_load_done) begin
          state_next = ST_START_UP;
        end
      end
      // illegal one-hot code
      default: begin
        state_next = ST_POWER_UP;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_reg <= ST_POWER_UP;
    end else begin
      state_reg <= state_next;
    end
  end

  // system state byte, written whole each cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sys_state_reg <= RST_BYTE;
    end else begin
      unique case (state_next)
        ST_POWER_UP: sys_state_reg <= SYS_POWER_UP;
        ST_START_UP: sys_state_reg <= SYS_START_UP;
        ST_CONFIG: sys_state_reg <= SYS_CONFIG;
        ST_OPER: sys_state_reg <= SYS_OPER;
        ST_OPER_NOENC: sys_state_reg <= SYS_OPER_NOENC;
        ST_BRAKE_TEST: sys_state_reg <= SYS_BRAKE_TEST;
        ST_FLASH: sys_state_reg <= SYS_FLASH;
        // never a code above 06h
        default: sys_state_reg <= SYS_POWER_UP;
      endcase
    end
  end

  // error severity and cause latch
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      err_sev_reg <= RST_BYTE;
      err_cause_reg <= RST_BYTE;
    end else if (err_sev_reg == SEV_INTERNAL) begin
      // held until power cycle
      err_sev_reg <= SEV_INTERNAL;
    end else if (new_cause != CAUSE_NONE &&
                 is_severe(new_cause)) begin
      // severe fault overrides an open io failure
      err_sev_reg <= SEV_INTERNAL;
      err_cause_reg <= new_cause;
    end else if (err_sev_reg == SEV_IO) begin
      if (ack_taken) begin
        // a fault in the same cycle wins over the clear
        err_sev_reg <= (new_cause != CAUSE_NONE) ? SEV_IO : SEV_NONE;
        err_cause_reg <= new_cause;
      end
    end else if (new_cause != CAUSE_NONE) begin
      err_sev_reg <= SEV_IO;
      err_cause_reg <= new_cause;
    end else begin
      // only 00h, 01h, 02h are ever stored
      err_sev_reg <= SEV_NONE;
      err_cause_reg <= CAUSE_NONE;
    end
  end

  // acknowledge request and input history
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ack_prev_reg <= 1'b0;
      ack_request_reg <= 1'b0;
    end else begin
      ack_prev_reg <= ack_in;
      // request only for an acknowledgeable failure
      ack_request_reg <= (err_sev_reg == SEV_IO) && !ack_taken;
    end
  end

  // feedback flags follow the monitored enables
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      fb_a_reg <= 1'b0;
      fb_b_reg <= 1'b0;
    end else begin
      fb_a_reg <= stage_en_mon_a;
      fb_b_reg <= stage_en_mon_b;
    end
  end

  // supply good flag and its control word copy
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      supply_good_reg <= 1'b0;
    end else begin
      supply_good_reg <= supply_ok;
    end
  end

  // power stage and brake release
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      power_stage_en_reg <= 1'b0;
      brake_release_reg <= 1'b0;
    end else begin
      // both channels at once, no error, operating
      power_stage_en_reg <= torque_off_en_a && torque_off_en_b &&
                            operating && (err_sev_reg == SEV_NONE) &&
                            (new_cause == CAUSE_NONE);
      // brake held during any failure
      brake_release_reg <= operating &&
                           (err_sev_reg == SEV_NONE) &&
                           (new_cause == CAUSE_NONE);
    end
  end

  // test pulse period counter
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pulse_cnt_reg <= '0;
    end else if (pulse_cnt_reg == 32'(PULSE_PERIOD - 1)) begin
      pulse_cnt_reg <= '0;
    end else begin
      pulse_cnt_reg <= pulse_cnt_reg + 32'h0000_0001;
    end
  end

  // safe output drive, low during each test pulse
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      safe_out_drive_reg <= 1'b0;
    end else begin
      safe_out_drive_reg <= safe_out_cmd &&
                            (pulse_cnt_reg >= 32'(PULSE_CYCLES));
    end
  end

  // level check at pulse end and one pulse width later
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      out_fault_reg <= 1'b0;
    end else if (pulse_cnt_reg == 32'(PULSE_CYCLES)) begin
      // last pulse cycle seen: level must be low
      out_fault_reg <= safe_out_level;
    end else if (pulse_cnt_reg == 32'(2 * PULSE_CYCLES)) begin
      // settled: level must match the drive
      out_fault_reg <= safe_out_level ^ safe_out_drive_reg;
    end else begin
      out_fault_reg <= 1'b0;
    end
  end

  // read data, one cycle after the strobe, read only
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_data_reg <= RST_BYTE;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        OFS_SYS_STATE: rd_data_reg <= sys_state_reg;
        OFS_ERR_SEV: rd_data_reg <= err_sev_reg;
        OFS_ERR_CAUSE: rd_data_reg <= err_cause_reg;
        OFS_FB_A: rd_data_reg <= {7'h00, fb_a_reg};
        OFS_FB_B: rd_data_reg <= {7'h00, fb_b_reg};
        OFS_SUPPLY: rd_data_reg <= {7'h00, supply_good_reg};
        OFS_OUT_STAT: rd_data_reg <= {5'h00, ack_request_reg,
                                      brake_release_reg,
                                      power_stage_en_reg};
        // unmapped and control reads answer zero
        default: rd_data_reg <= 8'h00;
      endcase
    end else begin
      rd_data_reg <= 8'h00;
    end
  end

  // outputs straight from flops
  assign rd_data = rd_data_reg;
  assign power_stage_en = power_stage_en_reg;
  assign brake_release = brake_release_reg;
  assign torque_off_ctrl_bit = supply_good_reg;
  assign safe_out_drive = safe_out_drive_reg;
  assign ack_request = ack_request_reg;
endmodule : ssm_status_monitor

// ---- ssm_pkg.sv ----
// Purpose: constants and types of the safety status monitor
// Assumes: 100 MHz ref_clk, synchronous inputs
// Notes on behaviour
// - power stage only with both enables active
// - supply good flag, copied to control bit
// - feedback a follows first stage enable
// - feedback b follows second stage enable
// - state 00h before start, 01h starting
// - state 02h when configuration is needed
// - state 03h operation, 04h without encoder
// - state 05h during processor started brake test
// - state 06h loading flash; 07h-FFh never
// - severity 00h none; 01h holds torque off, brake
// - severity 02h blocks operation until power cycle
// - severity never 03h-FFh
// - cause 00h none, 01h safe input fault
// - test pulse safe output, mismatch gives 02h
// - torque off output fault gives 03h
// - unrequested acknowledge toggle gives 04h
// - encoder link 05h, encoder check 06h
// - supply check 07h, fieldbus fault 08h
// - RAM fault 09h, firmware checksum 0Ah
// - CPU 0Bh, stack 0Ch, bad parameters 0Dh
package ssm_pkg;
  // register offsets, printed as the byte address
  localparam logic [15:0] OFS_SYS_STATE = 16'h1A01;
  localparam logic [15:0] OFS_ERR_SEV = 16'h1A02;
  localparam logic [15:0] OFS_ERR_CAUSE = 16'h1A03;
  localparam logic [15:0] OFS_FB_A = 16'h1A0E;
  localparam logic [15:0] OFS_FB_B = 16'h1A0F;
  localparam logic [15:0] OFS_SUPPLY = 16'h1A45;
  localparam logic [15:0] OFS_CTRL = 16'h1A80;
  localparam logic [15:0] OFS_OUT_STAT = 16'h1A81;
  // control register bit positions
  localparam int CTRL_BRK_START = 0;
  localparam int CTRL_BRK_END = 1;
  // system state codes
  localparam logic [7:0] SYS_POWER_UP = 8'h00;
  localparam logic [7:0] SYS_START_UP = 8'h01;
  localparam logic [7:0] SYS_CONFIG = 8'h02;
  localparam logic [7:0] SYS_OPER = 8'h03;
  localparam logic [7:0] SYS_OPER_NOENC = 8'h04;
  localparam logic [7:0] SYS_BRAKE_TEST = 8'h05;
  localparam logic [7:0] SYS_FLASH = 8'h06;
  // error severity codes
  localparam logic [7:0] SEV_NONE = 8'h00;
  localparam logic [7:0] SEV_IO = 8'h01;
  localparam logic [7:0] SEV_INTERNAL = 8'h02;
  // error cause codes
  localparam logic [7:0] CAUSE_NONE = 8'h00;
  localparam logic [7:0] CAUSE_SAFE_IN = 8'h01;
  localparam logic [7:0] CAUSE_SAFE_OUT = 8'h02;
  localparam logic [7:0] CAUSE_TQ_OUT = 8'h03;
  localparam logic [7:0] CAUSE_ACK = 8'h04;
  localparam logic [7:0] CAUSE_ENC_COMM = 8'h05;
  localparam logic [7:0] CAUSE_ENC_CHECK = 8'h06;
  localparam logic [7:0] CAUSE_SUPPLY = 8'h07;
  localparam logic [7:0] CAUSE_FIELDBUS = 8'h08;
  localparam logic [7:0] CAUSE_RAM = 8'h09;
  localparam logic [7:0] CAUSE_FW_CRC = 8'h0A;
  localparam logic [7:0] CAUSE_CPU = 8'h0B;
  localparam logic [7:0] CAUSE_STACK = 8'h0C;
  localparam logic [7:0] CAUSE_PARAM = 8'h0D;
  localparam int CAUSE_MAX = 13;
  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  // test pulse timing on the safe output
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_WIDTH_NS = 1000;
  localparam int PULSE_CYCLES =
    (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_PERIOD_US = 1000;
  localparam int PULSE_PERIOD_CYCLES =
    PULSE_PERIOD_US * 1000 / CLK_PERIOD_NS;
  // system state machine, one-hot
  typedef enum logic [6:0] {
    ST_POWER_UP = 7'h01,
    ST_START_UP = 7'h02,
    ST_CONFIG = 7'h04,
    ST_OPER = 7'h08,
    ST_OPER_NOENC = 7'h10,
    ST_BRAKE_TEST = 7'h20,
    ST_FLASH = 7'h40
  } ssm_state_e;
  // register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ssm_bus_s;
  // life cycle status from the module firmware
  typedef struct packed {
    logic module_start;
    logic link_up;
    logic config_bad;
    logic config_ok;
    logic encoder_active;
    logic flash_load_req;
    logic flash_load_done;
  } ssm_life_s;
  // fault reports from the internal diagnostics
  typedef struct packed {
    logic safe_input;
    logic torque_off_out;
    logic encoder_comm;
    logic encoder_check;
    logic fieldbus;
    logic ram;
    logic fw_crc;
    logic cpu;
    logic stack;
    logic param_invalid;
  } ssm_diag_s;
endpackage : ssm_pkg

// ---- ssm_status_checker_assertions.sv ----
// Purpose: port level assertions for the safety status monitor
// Assumes: one ref_clk domain, rst_b synchronous and active low
// Notes: bound to every instance of the monitor
`timescale 1ns/100ps
module ssm_status_checker
  import ssm_pkg::*;
#(
  parameter int PULSE_PERIOD = PULSE_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register port
  input wire ssm_pkg::ssm_bus_s bus_req,
  input wire logic [7:0] rd_data,
  // enables, monitors and power outputs
  input wire logic torque_off_en_a,
  input wire logic torque_off_en_b,
  input wire logic stage_en_mon_a,
  input wire logic stage_en_mon_b,
  input wire logic power_stage_en,
  input wire logic brake_release,
  // supply, acknowledge and diagnostics
  input wire logic supply_ok,
  input wire logic torque_off_ctrl_bit,
  input wire logic ack_in,
  input wire logic ack_request,
  input wire ssm_pkg::ssm_diag_s diag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // remembers any RAM, firmware checksum, CPU or stack fault since reset
  logic severe_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      severe_reg <= 1'b0;
    end else if (diag.ram | diag.cpu | diag.stack | diag.fw_crc) begin
      severe_reg <= 1'b1;
    end
  end
  property p_pwr_dual;
    power_stage_en |-> $past(torque_off_en_a && torque_off_en_b);
  endproperty
  a_pwr_dual: assert property (p_pwr_dual)
    else $error("power stage on without both enables");
  property p_ctrl_copy;
    $past(rst_b) |-> torque_off_ctrl_bit == $past(supply_ok);
  endproperty
  a_ctrl_copy: assert property (p_ctrl_copy)
    else $error("control bit does not follow supply good");
  property p_fb_a;
    $past(bus_req.rd) && $past(bus_req.addr) == OFS_FB_A
      |-> rd_data == {7'h00, $past(stage_en_mon_a, 2)};
  endproperty
  a_fb_a: assert property (p_fb_a)
    else $error("feedback a read wrong");
  property p_fb_b;
    $past(bus_req.rd) && $past(bus_req.addr) == OFS_FB_B
      |-> rd_data == {7'h00, $past(stage_en_mon_b, 2)};
  endproperty
  a_fb_b: assert property (p_fb_b)
    else $error("feedback b read wrong");
  property p_fault_off;
    diag.safe_input |=> (!power_stage_en && !brake_release) [*2];
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("outputs released during a fault");
  property p_ack_req;
    brake_release && diag.encoder_comm && !diag.torque_off_out
      |-> ##[1:3] ack_request;
  endproperty
  a_ack_req: assert property (p_ack_req)
    else $error("no acknowledge request after fault");
  property p_severe_hold;
    severe_reg |-> !power_stage_en && !brake_release;
  endproperty
  a_severe_hold: assert property (p_severe_hold)
    else $error("operation released after severe fault");
  property p_stray_ack;
    brake_release && !ack_request && ack_in != $past(ack_in)
      |-> ##[1:2] !brake_release;
  endproperty
  a_stray_ack: assert property (p_stray_ack)
    else $error("stray acknowledge toggle not caught");
  property p_sev_range;
    $past(bus_req.rd) && $past(bus_req.addr) == OFS_ERR_SEV
      |-> rd_data <= SEV_INTERNAL;
  endproperty
  a_sev_range: assert property (p_sev_range)
    else $error("severity out of range");
  property p_sys_range;
    $past(bus_req.rd) && $past(bus_req.addr) == OFS_SYS_STATE
      |-> rd_data <= SYS_FLASH;
  endproperty
  a_sys_range: assert property (p_sys_range)
    else $error("system state out of range");
  property p_rd_idle;
    !$past(bus_req.rd) |-> rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its cycle");
endmodule : ssm_status_checker

bind ssm_status_monitor ssm_status_checker #(
  .PULSE_PERIOD(PULSE_PERIOD)
) chk_i (
  .ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
  .torque_off_en_a(torque_off_en_a), .torque_off_en_b(torque_off_en_b),
  .stage_en_mon_a(stage_en_mon_a), .stage_en_mon_b(stage_en_mon_b),
  .power_stage_en(power_stage_en), .brake_release(brake_release),
  .supply_ok(supply_ok), .torque_off_ctrl_bit(torque_off_ctrl_bit),
  .ack_in(ack_in), .ack_request(ack_request), .diag(diag)
);

// ---- ssm_field_model.sv ----
// Purpose: acknowledge logic and safe output pin outside the monitor
// Assumes: go strobes arrive one cycle long after a rising edge
// Notes: stray_go toggles without a request, on purpose
`timescale 1ns/100ps
module ssm_field_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // acknowledge side
  input wire logic ack_request,
  input wire logic ack_go,
  input wire logic stray_go,
  output logic ack_in,
  // safe output pin
  input wire logic safe_out_drive,
  input wire logic pin_stuck,
  output logic safe_out_level
);
  // toggle only when asked, unless a stray toggle is ordered
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ack_in <= 1'b0;
    end else if ((ack_go && ack_request) || stray_go) begin
      ack_in <= ~ack_in;
    end
  end
  // pin reads back its drive unless shorted high
  assign safe_out_level = pin_stuck | safe_out_drive;
endmodule : ssm_field_model

// ---- tb_top.sv ----
// Purpose: register level test of the safety status monitor
// Assumes: 100 MHz ref_clk, short test pulse period of 400
// Notes: expectations come from the package codes
`timescale 1ns/100ps
module tb_top;
  import ssm_pkg::*;
  // stimulus and observed signals
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  ssm_bus_s bus = '0;
  ssm_life_s life = '0;
  ssm_diag_s diag = '0;
  logic [7:0] rd_data;
  logic en_a = 1'b0, en_b = 1'b0, mon_a = 1'b0, mon_b = 1'b0;
  logic supply_ok = 1'b1, cmd = 1'b0, pin_stuck = 1'b0;
  logic ack_go = 1'b0, stray_go = 1'b0;
  logic pwr, brk, ctrl_bit, drive, level, ack_in, ack_req;
  int err_count = 0;
  int checked = 0;
  // cycles the safe output stays low in one test pulse
  int pulse_len = 0;
  logic [7:0] codes [11] = '{8'h01, 8'h05, 8'h06, 8'h08, 8'h0D,
    8'h03, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h07};
  int bits [11] = '{9, 7, 6, 5, 0, 8, 4, 3, 2, 1, 0};
  logic [6:0] lifes [8] = '{7'h40, 7'h10, 7'h08, 7'h02, 7'h01,
    7'h24, 7'h20, 7'h24};
  logic [7:0] states [8] = '{8'h01, 8'h02, 8'h01, 8'h06, 8'h01,
    8'h03, 8'h04, 8'h03};
  always #5 ref_clk = ~ref_clk;
  ssm_status_monitor #(.PULSE_PERIOD(400)) ssm_status_monitor_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus), .rd_data(rd_data),
    .torque_off_en_a(en_a), .torque_off_en_b(en_b),
    .stage_en_mon_a(mon_a), .stage_en_mon_b(mon_b),
    .power_stage_en(pwr), .brake_release(brk), .supply_ok(supply_ok),
    .torque_off_ctrl_bit(ctrl_bit), .safe_out_cmd(cmd),
    .safe_out_level(level), .safe_out_drive(drive), .ack_in(ack_in),
    .ack_request(ack_req), .life(life), .diag(diag));
  ssm_field_model ssm_field_model_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .ack_request(ack_req),
    .ack_go(ack_go), .stray_go(stray_go), .ack_in(ack_in),
    .safe_out_drive(drive), .pin_stuck(pin_stuck),
    .safe_out_level(level));
  // compare one value and count it
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask : wr
  // one cycle read strobe, data checked in the next cycle
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    // data launched at the last edge stands until this one takes effect
    @(posedge ref_clk);
    chk(rd_data, exp);
  endtask : rd
  // one cycle strobe on one diagnostic input
  task automatic fault(input int n);
    @(posedge ref_clk);
    diag <= ssm_diag_s'(10'h001 << n);
    @(posedge ref_clk);
    diag <= '0;
  endtask : fault
  task automatic ack(input logic stray);
    @(posedge ref_clk);
    if (stray) stray_go <= 1'b1;
    else ack_go <= 1'b1;
    @(posedge ref_clk);
    {ack_go, stray_go} <= 2'b00;
    repeat (3) @(posedge ref_clk);
  endtask : ack
  // reset and bring the monitor into operation
  task automatic restart();
    rst_b <= 1'b0;
    life <= '0;
    supply_ok <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    life <= ssm_life_s'(7'h64);
    repeat (4) @(posedge ref_clk);
  endtask : restart
  task automatic conclude();
    $display("errors %0d of %0d compares", err_count, checked);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    conclude();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(OFS_SYS_STATE, SYS_POWER_UP);
    rd(OFS_ERR_CAUSE, CAUSE_NONE);
    for (int i = 0; i < 8; i++) begin
      life <= ssm_life_s'(lifes[i]);
      repeat (2) @(posedge ref_clk);
      rd(OFS_SYS_STATE, states[i]);
    end
    wr(OFS_CTRL, 8'h01);
    rd(OFS_SYS_STATE, SYS_BRAKE_TEST);
    wr(OFS_SYS_STATE, 8'hFF);
    rd(OFS_SYS_STATE, SYS_BRAKE_TEST);
    wr(OFS_CTRL, 8'h02);
    rd(OFS_SYS_STATE, SYS_OPER);
    mon_a <= 1'b1;
    rd(OFS_FB_A, 8'h01);
    rd(OFS_FB_B, 8'h00);
    {mon_a, mon_b} <= 2'b01;
    rd(OFS_FB_A, 8'h00);
    rd(OFS_FB_B, 8'h01);
    rd(OFS_SUPPLY, 8'h01);
    chk({7'h00, ctrl_bit}, 8'h01);
    en_a <= 1'b1;
    rd(OFS_OUT_STAT, 8'h02);
    en_b <= 1'b1;
    rd(OFS_OUT_STAT, 8'h03);
    rd(16'h1A10, 8'h00);
    rd(OFS_CTRL, 8'h00);
    for (int i = 0; i < 5; i++) begin
      fault(bits[i]);
      rd(OFS_ERR_SEV, SEV_IO);
      rd(OFS_ERR_CAUSE, codes[i]);
      rd(OFS_OUT_STAT, 8'h04);
      ack(1'b0);
      rd(OFS_ERR_SEV, SEV_NONE);
      rd(OFS_OUT_STAT, 8'h03);
    end
    @(posedge ref_clk);
    diag <= ssm_diag_s'(10'h0A0);
    fault(9);
    rd(OFS_ERR_CAUSE, CAUSE_ENC_COMM);
    ack(1'b0);
    ack(1'b1);
    rd(OFS_ERR_CAUSE, CAUSE_ACK);
    ack(1'b0);
    cmd <= 1'b1;
    repeat (450) @(posedge ref_clk);
    rd(OFS_ERR_CAUSE, CAUSE_NONE);
    // measure one test pulse on the drive, sampled mid cycle
    @(negedge drive);
    @(negedge ref_clk);
    while (drive === 1'b0) begin
      pulse_len++;
      @(negedge ref_clk);
    end
    chk(8'(pulse_len), 8'(PULSE_CYCLES));
    @(posedge ref_clk);
    pin_stuck <= 1'b1;
    repeat (450) @(posedge ref_clk);
    rd(OFS_ERR_CAUSE, CAUSE_SAFE_OUT);
    pin_stuck <= 1'b0;
    cmd <= 1'b0;
    for (int i = 5; i < 11; i++) begin
      restart();
      if (i < 10) fault(bits[i]);
      else supply_ok <= 1'b0;
      repeat (20) @(posedge ref_clk);
      if (i == 10) rd(OFS_SUPPLY, 8'h00);
      rd(OFS_ERR_SEV, SEV_INTERNAL);
      rd(OFS_ERR_CAUSE, codes[i]);
      rd(OFS_OUT_STAT, 8'h00);
    end
    conclude();
  end
endmodule : tb_top
